// [src/mpp_top.sv]
// Strobed register access was decided locally.
module mpp_top
   import mpp_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic warm_rst,
   input wire logic [1:0] mode_strap,
   input wire logic [mpp_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [mpp_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_we,
   input wire logic reg_re,
   output logic [mpp_pkg::DATA_W-1:0] reg_rdata,
   input wire logic [mpp_pkg::DATA_W-1:0] port_d_pin_in,
   output logic [mpp_pkg::DATA_W-1:0] port_d_pin_out,
   output logic [mpp_pkg::DATA_W-1:0] port_d_pin_oe_n,
   input wire logic [mpp_pkg::DATA_W-1:0] port_f_pin_in,
   output logic [mpp_pkg::DATA_W-1:0] port_f_pin_out,
   output logic [mpp_pkg::DATA_W-1:0] port_f_pin_oe_n,
   input wire logic [mpp_pkg::DATA_W-1:0] port_j_pin_in,
   output logic [mpp_pkg::DATA_W-1:0] port_j_pin_out,
   output logic [mpp_pkg::DATA_W-1:0] port_j_pin_oe_n,
   input wire logic [mpp_pkg::DATA_W-1:0] bus_upper_addr_data_byte_out,
   input wire logic bus_upper_drive,
   output logic [mpp_pkg::DATA_W-1:0] bus_upper_addr_data_byte_in,
   output logic bus_active,
   output logic [mpp_pkg::DATA_W-1:0] adc_channel_analog
);
   import mpp_pkg::*;

   // Three ports share one port module; only their overrides differ.
   // Port D yields to the external bus, port F to the converter,
   // and port J has no alternate function at all.
   // Every pin output and enable is registered inside the port module,
   // so all top-level pin outputs come straight from flip-flops.
   // The cost is one cycle between a register write and the pins.

   // Processor mode caught from the strap while the cold reset is held
   mpp_mode_type mode;
   // Converter configuration; decides analog or digital use of port F
   logic [DATA_W-1:0] converter_config_one;
   // Port F digital switch taken from the configuration
   logic port_f_digital;
   // Bus ownership of port D, derived from the mode
   // Fixed between cold resets because the mode is
   logic bus_mode;

   // Write strobes per register
   // Each strobe lasts the one cycle of the bus write
   logic we_d_data;
   logic we_d_dir;
   logic we_f_data;
   logic we_f_dir;
   logic we_j_data;
   logic we_j_dir;
   logic we_conv;

   // Direction views from each port; the latches stay inside the ports
   logic [DATA_W-1:0] d_direction;
   logic [DATA_W-1:0] f_direction;
   logic [DATA_W-1:0] j_direction;

   // Read mux result before registering
   // Zero when idle so the read data never holds a stale value
   logic [DATA_W-1:0] next_reg_rdata;
   // Port D drive request while the bus owns the pins
   logic [DATA_W-1:0] bus_oe_n;

   // The bank select register lives in the core; what reaches this block
   // is the bank already merged into the upper address nibble.
   // A full compare keeps aliases out: one register, one address.
   // Match a bus address against a bank and offset pair
   function automatic logic reg_hit(
      input logic [ADDR_W-1:0] addr,
      input logic [BANK_W-1:0] bank,
      input logic [OFFS_W-1:0] offs
   );
      reg_hit = (addr == {bank, offs});
   endfunction : reg_hit

   // Unknown strap codes cannot occur on two bits, but the default arm
   // still picks a mode that keeps port D as plain I/O, the safer choice.
   // Decode the strap into the one-hot mode
   function automatic mpp_mode_type decode_mode(input logic [1:0] strap);
      mpp_mode_type m;
      m = MPP_MODE_MICROCONTROLLER;
      case (strap)
         STRAP_MICROPROCESSOR: m = MPP_MODE_MICROPROCESSOR;
         STRAP_MICROCONTROLLER: m = MPP_MODE_MICROCONTROLLER;
         STRAP_EXTENDED_MICROCONTROLLER: m = MPP_MODE_EXTENDED;
         STRAP_PROTECTED_MICROCONTROLLER: m = MPP_MODE_PROTECTED;
         default: m = MPP_MODE_MICROCONTROLLER;
      endcase
      decode_mode = m;
   endfunction : decode_mode

   // Configuration strap is sampled during the cold reset only,
   // so the mode cannot change under running software
   // Hold the cold reset for two edges so the strap is surely caught
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         mode <= decode_mode(mode_strap);
      end
   end

   // Bus owns port D in the two external-memory modes
   // Only the modes that fetch from outside need the upper address byte;
   // the other two leave every port D pin to software
   always_comb begin
      case (mode)
         MPP_MODE_MICROPROCESSOR: bus_mode = 1'b1;
         MPP_MODE_EXTENDED: bus_mode = 1'b1;
         MPP_MODE_MICROCONTROLLER: bus_mode = 1'b0;
         MPP_MODE_PROTECTED: bus_mode = 1'b0;
         default: bus_mode = 1'b0;
      endcase
   end

   // Bank and offset are one flat address here; keeping the bank select
   // pointed at the right bank is software's job, so a wrong bank simply
   // misses these registers
   always_comb begin
      we_d_data = 1'b0;
      we_d_dir = 1'b0;
      we_f_data = 1'b0;
      we_f_dir = 1'b0;
      we_j_data = 1'b0;
      we_j_dir = 1'b0;
      we_conv = 1'b0;
      // Defaults above make every miss a no-op, including writes to a
      // register of the wrong bank and writes to unmapped offsets
      // Port J sits alone in its bank among these registers
      if (!reg_we) begin
         // No write this cycle
      end else if (reg_hit(reg_addr, BANK_PORT_D, OFF_PORT_D_DATA)) begin
         we_d_data = 1'b1;
      end else if (reg_hit(reg_addr, BANK_PORT_D, OFF_PORT_D_DIRECTION)) begin
         we_d_dir = 1'b1;
      end else if (reg_hit(reg_addr, BANK_PORT_F, OFF_PORT_F_DATA)) begin
         we_f_data = 1'b1;
      end else if (reg_hit(reg_addr, BANK_PORT_F, OFF_PORT_F_DIRECTION)) begin
         we_f_dir = 1'b1;
      end else if (reg_hit(reg_addr, BANK_CONVERTER, OFF_CONVERTER_CONFIG_ONE)) begin
         we_conv = 1'b1;
      end else if (reg_hit(reg_addr, BANK_PORT_J, OFF_PORT_J_DATA)) begin
         we_j_data = 1'b1;
      end else if (reg_hit(reg_addr, BANK_PORT_J, OFF_PORT_J_DIRECTION)) begin
         we_j_dir = 1'b1;
      end
   end

   // Only bit 0 of the configuration acts in this block; the other bits
   // are stored and read back so software sees what it wrote
   // Converter configuration returns to analog on every reset
   always_ff @(posedge clk) begin
      if (sys_rst || warm_rst) begin
         converter_config_one <= CONVERTER_CONFIG_RESET;
      end else if (we_conv) begin
         converter_config_one <= reg_wdata;
      end
   end

   assign port_f_digital = converter_config_one[CONV_DIGITAL_BIT];

   // Bus drive request turned into per-pin enables, active low
   // One enable for the whole byte: the bus drives all eight lines or none
   assign bus_oe_n = bus_upper_drive ? ALL_LOW : ALL_RELEASED;

   // Port D: plain I/O, or upper address/data byte of the external bus
   // Latch and direction stay writable in bus mode; they only take effect
   // if the mode changes, which needs a cold reset that clears them anyway
   mpp_port u_port_d (
      .clk(clk),
      .sys_rst(sys_rst),
      .warm_rst(warm_rst),
      .data_we(we_d_data),
      .dir_we(we_d_dir),
      .wdata(reg_wdata),
      .force_en(bus_mode),
      .force_out(bus_upper_addr_data_byte_out),
      .force_oe_n(bus_oe_n),
      .latch(),
      .direction(d_direction),
      .pin_out(port_d_pin_out),
      .pin_oe_n(port_d_pin_oe_n)
   );

   // Port F: analog pins hold the drivers off whatever direction says
   // Direction and latch writes made while analog are kept and take
   // effect at the switch to digital
   mpp_port u_port_f (
      .clk(clk),
      .sys_rst(sys_rst),
      .warm_rst(warm_rst),
      .data_we(we_f_data),
      .dir_we(we_f_dir),
      .wdata(reg_wdata),
      .force_en(!port_f_digital),
      .force_out(ALL_LOW),
      .force_oe_n(ALL_RELEASED),
      .latch(),
      .direction(f_direction),
      .pin_out(port_f_pin_out),
      .pin_oe_n(port_f_pin_oe_n)
   );

   // Port J: plain digital I/O, no alternate function
   // Warm reset keeps its latch, so the first output after a warm
   // reset drives the value software left there
   mpp_port u_port_j (
      .clk(clk),
      .sys_rst(sys_rst),
      .warm_rst(warm_rst),
      .data_we(we_j_data),
      .dir_we(we_j_dir),
      .wdata(reg_wdata),
      .force_en(1'b0),
      .force_out(ALL_LOW),
      .force_oe_n(ALL_RELEASED),
      .latch(),
      .direction(j_direction),
      .pin_out(port_j_pin_out),
      .pin_oe_n(port_j_pin_oe_n)
   );

   // Read mux; data registers return the pins, not the latches
   // Latches are never read back: a read that showed the latch would hide
   // a shorted or overloaded output pin from software.
   // Pins are sampled here once, and the registered result is what the
   // core sees, so the read is one clean cycle late
   always_comb begin
      next_reg_rdata = READ_UNMAPPED;
      if (!reg_re) begin
         // Idle cycles read as zero
         next_reg_rdata = READ_UNMAPPED;
      end else if (reg_hit(reg_addr, BANK_PORT_D, OFF_PORT_D_DATA)) begin
         next_reg_rdata = port_d_pin_in;
      end else if (reg_hit(reg_addr, BANK_PORT_D, OFF_PORT_D_DIRECTION)) begin
         next_reg_rdata = d_direction;
      end else if (reg_hit(reg_addr, BANK_PORT_F, OFF_PORT_F_DATA)) begin
         // Analog pins read low so converter voltages never show as data
         next_reg_rdata = port_f_digital ? port_f_pin_in : ALL_LOW;
      end else if (reg_hit(reg_addr, BANK_PORT_F, OFF_PORT_F_DIRECTION)) begin
         next_reg_rdata = f_direction;
      end else if (reg_hit(reg_addr, BANK_CONVERTER, OFF_CONVERTER_CONFIG_ONE)) begin
         next_reg_rdata = converter_config_one;
      end else if (reg_hit(reg_addr, BANK_PORT_J, OFF_PORT_J_DATA)) begin
         next_reg_rdata = port_j_pin_in;
      end else if (reg_hit(reg_addr, BANK_PORT_J, OFF_PORT_J_DIRECTION)) begin
         next_reg_rdata = j_direction;
      end
   end

   // Read data stands one cycle after the strobe and only then
   // Warm reset leaves the read path alone; it holds no state of its own
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         reg_rdata <= READ_UNMAPPED;
      end else begin
         reg_rdata <= next_reg_rdata;
      end
   end

   // Upper byte seen on the port D pins, handed to the bus controller
   // Captured byte is forced low outside bus mode so a stray pin level
   // never reaches the bus controller
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         bus_upper_addr_data_byte_in <= ALL_LOW;
         bus_active <= 1'b0;
      end else begin
         bus_upper_addr_data_byte_in <= bus_mode ? port_d_pin_in : ALL_LOW;
         bus_active <= bus_mode;
      end
   end

   // Tell the converter which channels are analog; all of them until
   // software switches port F to digital
   // Limitation: all eight channels switch together; there is no
   // per-channel analog selection in this block
   always_ff @(posedge clk) begin
      if (sys_rst || warm_rst) begin
         adc_channel_analog <= ALL_RELEASED;
      end else begin
         adc_channel_analog <= port_f_digital ? ALL_LOW : ALL_RELEASED;
      end
   end

endmodule : mpp_top

// [src/mpp_pkg.sv]
package mpp_pkg;
   // Widths of the register port
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;
   localparam int BANK_W = 4;
   localparam int OFFS_W = 8;

   // Bank numbers; the upper address nibble carries the bank selection
   localparam logic [BANK_W-1:0] BANK_PORT_D = 4'h1;
   localparam logic [BANK_W-1:0] BANK_PORT_F = 4'h5;
   localparam logic [BANK_W-1:0] BANK_PORT_J = 4'h8;
   localparam logic [BANK_W-1:0] BANK_CONVERTER = 4'h5;

   // Register offsets inside their bank
   localparam logic [OFFS_W-1:0] OFF_PORT_D_DATA = 8'h10;
   localparam logic [OFFS_W-1:0] OFF_PORT_D_DIRECTION = 8'h11;
   localparam logic [OFFS_W-1:0] OFF_PORT_F_DATA = 8'h14;
   localparam logic [OFFS_W-1:0] OFF_PORT_F_DIRECTION = 8'h15;
   localparam logic [OFFS_W-1:0] OFF_CONVERTER_CONFIG_ONE = 8'h16;
   localparam logic [OFFS_W-1:0] OFF_PORT_J_DIRECTION = 8'h12;
   localparam logic [OFFS_W-1:0] OFF_PORT_J_DATA = 8'h13;

   // Values after reset
   localparam logic [DATA_W-1:0] DIRECTION_RESET = 8'hFF;
   localparam logic [DATA_W-1:0] LATCH_RESET = 8'h00;
   localparam logic [DATA_W-1:0] CONVERTER_CONFIG_RESET = 8'h00;
   localparam logic [DATA_W-1:0] READ_UNMAPPED = 8'h00;
   localparam logic [DATA_W-1:0] ALL_RELEASED = 8'hFF;
   localparam logic [DATA_W-1:0] ALL_LOW = 8'h00;

   // Field position: set makes port F digital, clear keeps it analog
   localparam int CONV_DIGITAL_BIT = 0;

   // Processor-mode configuration strap codes
   localparam logic [1:0] STRAP_MICROPROCESSOR = 2'h0;
   localparam logic [1:0] STRAP_MICROCONTROLLER = 2'h1;
   localparam logic [1:0] STRAP_EXTENDED_MICROCONTROLLER = 2'h2;
   localparam logic [1:0] STRAP_PROTECTED_MICROCONTROLLER = 2'h3;

   // Decoded processor mode, one-hot
   typedef enum logic [3:0] {
      MPP_MODE_MICROPROCESSOR = 4'h1,
      MPP_MODE_MICROCONTROLLER = 4'h2,
      MPP_MODE_EXTENDED = 4'h4,
      MPP_MODE_PROTECTED = 4'h8
   } mpp_mode_type;
endpackage : mpp_pkg

// [src/mpp_port.sv]
module mpp_port
   import mpp_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic warm_rst,
   input wire logic data_we,
   input wire logic dir_we,
   input wire logic [mpp_pkg::DATA_W-1:0] wdata,
   input wire logic force_en,
   input wire logic [mpp_pkg::DATA_W-1:0] force_out,
   input wire logic [mpp_pkg::DATA_W-1:0] force_oe_n,
   output logic [mpp_pkg::DATA_W-1:0] latch,
   output logic [mpp_pkg::DATA_W-1:0] direction,
   output logic [mpp_pkg::DATA_W-1:0] pin_out,
   output logic [mpp_pkg::DATA_W-1:0] pin_oe_n
);
   // Output latch: cleared only by the cold reset, kept by the warm one
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         latch <= LATCH_RESET;
      end else if (data_we) begin
         // Writes go to the latch only, never to the pins directly
         latch <= wdata;
      end
   end

   // Direction: every reset makes all pins inputs
   always_ff @(posedge clk) begin
      if (sys_rst || warm_rst) begin
         direction <= DIRECTION_RESET;
      end else if (dir_we) begin
         direction <= wdata;
      end
   end

   // Pin drivers; a one in direction releases the pin, a zero drives the latch
   // Registered so the pins never glitch on decode; costs one cycle of latency
   always_ff @(posedge clk) begin
      if (sys_rst || warm_rst) begin
         pin_out <= ALL_LOW;
         pin_oe_n <= ALL_RELEASED;
      end else if (force_en) begin
         // Alternate function owns the pins
         pin_out <= force_out;
         pin_oe_n <= force_oe_n;
      end else begin
         pin_out <= latch;
         pin_oe_n <= direction;
      end
   end
endmodule : mpp_port

// [sim/mpp_top_props.sv]
module mpp_top_props
   import mpp_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic warm_rst,
   input wire logic [mpp_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [mpp_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_we,
   input wire logic reg_re,
   input wire logic [mpp_pkg::DATA_W-1:0] reg_rdata,
   input wire logic [mpp_pkg::DATA_W-1:0] port_d_pin_in,
   input wire logic [mpp_pkg::DATA_W-1:0] port_d_pin_out,
   input wire logic [mpp_pkg::DATA_W-1:0] port_d_pin_oe_n,
   input wire logic [mpp_pkg::DATA_W-1:0] port_f_pin_out,
   input wire logic [mpp_pkg::DATA_W-1:0] port_f_pin_oe_n,
   input wire logic [mpp_pkg::DATA_W-1:0] port_j_pin_in,
   input wire logic [mpp_pkg::DATA_W-1:0] port_j_pin_oe_n,
   input wire logic [mpp_pkg::DATA_W-1:0] bus_upper_addr_data_byte_out,
   input wire logic bus_upper_drive,
   input wire logic [mpp_pkg::DATA_W-1:0] bus_upper_addr_data_byte_in,
   input wire logic bus_active,
   input wire logic [mpp_pkg::DATA_W-1:0] adc_channel_analog
);
   timeunit 1ns;
   timeprecision 100ps;
   // Single clock domain, cold reset aborts every attempt
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_read_idle_zero: assert property (!reg_re |=> reg_rdata == READ_UNMAPPED)
      else $error("read data not zero outside a read");
   a_read_pins_j: assert property (reg_re && reg_addr == {BANK_PORT_J, OFF_PORT_J_DATA}
      |=> reg_rdata == $past(port_j_pin_in)) else $error("port J read not pin level");
   a_read_unmapped: assert property (reg_re && reg_addr[11:8] == 4'h0
      |=> reg_rdata == READ_UNMAPPED) else $error("unmapped read not zero");
   a_cold_release: assert property ($fell(sys_rst) |-> adc_channel_analog == ALL_RELEASED
      && port_f_pin_oe_n == ALL_RELEASED && port_j_pin_oe_n == ALL_RELEASED)
      else $error("pins not released after cold reset");
   // Warm reset releases the pins at the same edge as it resets direction
   a_warm_release: assert property (warm_rst |-> ##2 (port_j_pin_oe_n == ALL_RELEASED
      && adc_channel_analog == ALL_RELEASED)) else $error("warm reset left pins set");
   a_dir_to_pins: assert property ((reg_we && reg_addr == {BANK_PORT_J, OFF_PORT_J_DIRECTION}
      && !warm_rst) ##1 (!reg_we && !warm_rst) |=> port_j_pin_oe_n == $past(reg_wdata, 2))
      else $error("port J direction not on pins");
   a_bus_drive: assert property (bus_active && $past(bus_active) && !$past(warm_rst) |->
      port_d_pin_out == $past(bus_upper_addr_data_byte_out) && port_d_pin_oe_n ==
      ($past(bus_upper_drive) ? ALL_LOW : ALL_RELEASED)) else $error("bus byte not on D");
   a_bus_capture: assert property (bus_active && $past(bus_active) |->
      bus_upper_addr_data_byte_in == $past(port_d_pin_in)) else $error("bus capture wrong");
   a_bus_off_quiet: assert property (!bus_active && $past(!bus_active) |->
      bus_upper_addr_data_byte_in == ALL_LOW) else $error("bus byte outside bus mode");
   a_analog_pins: assert property (adc_channel_analog == ALL_RELEASED |->
      port_f_pin_oe_n == ALL_RELEASED && port_f_pin_out == ALL_LOW)
      else $error("analog port F driven");
endmodule : mpp_top_props

bind mpp_top mpp_top_props u_mpp_top_props (.clk(clk), .sys_rst(sys_rst), .warm_rst(warm_rst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
   .reg_rdata(reg_rdata), .port_d_pin_in(port_d_pin_in), .port_d_pin_out(port_d_pin_out),
   .port_d_pin_oe_n(port_d_pin_oe_n), .port_f_pin_out(port_f_pin_out),
   .port_f_pin_oe_n(port_f_pin_oe_n), .port_j_pin_in(port_j_pin_in),
   .port_j_pin_oe_n(port_j_pin_oe_n),
   .bus_upper_addr_data_byte_out(bus_upper_addr_data_byte_out),
   .bus_upper_drive(bus_upper_drive),
   .bus_upper_addr_data_byte_in(bus_upper_addr_data_byte_in), .bus_active(bus_active),
   .adc_channel_analog(adc_channel_analog));

// [sim/mpp_pin_model.sv]
module mpp_pin_model
   import mpp_pkg::*;
(
   input wire logic [mpp_pkg::DATA_W-1:0] ext_level,
   input wire logic [mpp_pkg::DATA_W-1:0] pin_out,
   input wire logic [mpp_pkg::DATA_W-1:0] pin_oe_n,
   output logic [mpp_pkg::DATA_W-1:0] pin_in
);
   timeunit 1ns;
   timeprecision 100ps;
   // Released pins show the outside driver, driven pins show our value
   assign pin_in = (pin_oe_n & ext_level) | (~pin_oe_n & pin_out);
endmodule : mpp_pin_model

// [sim/multiplexed_parallel_ports_test.sv]
module multiplexed_parallel_ports_test
   import mpp_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   // Outside levels differ per bit so misrouted bits show up
   localparam logic [7:0] EXT_D = 8'h3C, EXT_F = 8'h5A, EXT_J = 8'hA5;
   localparam logic [11:0] A_JR = {BANK_PORT_J, OFF_PORT_J_DIRECTION};
   localparam logic [11:0] A_JD = {BANK_PORT_J, OFF_PORT_J_DATA};
   localparam logic [11:0] A_DR = {BANK_PORT_D, OFF_PORT_D_DIRECTION};
   localparam logic [11:0] A_DD = {BANK_PORT_D, OFF_PORT_D_DATA};
   localparam logic [11:0] A_FR = {BANK_PORT_F, OFF_PORT_F_DIRECTION};
   localparam logic [11:0] A_FD = {BANK_PORT_F, OFF_PORT_F_DATA};
   localparam logic [11:0] A_FC = {BANK_CONVERTER, OFF_CONVERTER_CONFIG_ONE};
   // One register access: write data, or expected read data
   typedef struct packed {logic [11:0] a; logic we; logic [7:0] d;} mpp_row_type;
   mpp_row_type rows [17] = '{
      '{A_JR, 1'b0, 8'hFF}, '{A_JD, 1'b0, EXT_J},
      '{A_JD, 1'b1, 8'h0F}, '{A_JR, 1'b1, 8'hF0},
      '{A_JD, 1'b0, 8'hAF}, '{A_JR, 1'b0, 8'hF0},
      '{A_DD, 1'b1, 8'h55}, '{A_DR, 1'b1, 8'h0F},
      '{A_DD, 1'b0, 8'h5C}, '{A_DR, 1'b0, 8'h0F},
      '{A_FD, 1'b0, 8'h00}, '{A_FC, 1'b1, 8'h01},
      '{A_FD, 1'b1, 8'hC3}, '{A_FR, 1'b1, 8'h03},
      '{A_FD, 1'b0, 8'hC2}, '{A_FR, 1'b0, 8'h03},
      '{12'h000, 1'b0, 8'h00}};
   logic [1:0] straps [4] = '{STRAP_MICROPROCESSOR, STRAP_MICROCONTROLLER,
      STRAP_PROTECTED_MICROCONTROLLER, STRAP_EXTENDED_MICROCONTROLLER};
   logic clk = 1'b0, sys_rst = 1'b1, warm_rst = 1'b0, reg_we = 1'b0, reg_re = 1'b0;
   logic bus_upper_drive = 1'b0, bus_active;
   logic [1:0] mode_strap = STRAP_MICROCONTROLLER;
   logic [11:0] reg_addr = 12'h000;
   logic [7:0] reg_wdata = 8'h00, bus_out = 8'h00, reg_rdata, bus_in, adc;
   logic [7:0] d_in, d_out, d_oe, f_in, f_out, f_oe, j_in, j_out, j_oe;
   int err_count = 0, n_tests = 0;

   always #50 clk = ~clk;

   mpp_top u_mpp_top (.clk(clk), .sys_rst(sys_rst), .warm_rst(warm_rst),
      .mode_strap(mode_strap), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
      .reg_re(reg_re), .reg_rdata(reg_rdata), .port_d_pin_in(d_in), .port_d_pin_out(d_out),
      .port_d_pin_oe_n(d_oe), .port_f_pin_in(f_in), .port_f_pin_out(f_out),
      .port_f_pin_oe_n(f_oe), .port_j_pin_in(j_in), .port_j_pin_out(j_out),
      .port_j_pin_oe_n(j_oe), .bus_upper_addr_data_byte_out(bus_out),
      .bus_upper_drive(bus_upper_drive), .bus_upper_addr_data_byte_in(bus_in),
      .bus_active(bus_active), .adc_channel_analog(adc));
   mpp_pin_model u_mpp_pin_model_d (.ext_level(EXT_D), .pin_out(d_out), .pin_oe_n(d_oe),
      .pin_in(d_in));
   mpp_pin_model u_mpp_pin_model_f (.ext_level(EXT_F), .pin_out(f_out), .pin_oe_n(f_oe),
      .pin_in(f_in));
   mpp_pin_model u_mpp_pin_model_j (.ext_level(EXT_J), .pin_out(j_out), .pin_oe_n(j_oe),
      .pin_in(j_in));

   // Compare and count
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Write, then idle so pins settle before any read samples them
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_we <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_we <= 1'b0;
      repeat (2) @(posedge clk);
   endtask : wr

   // Read data stand one cycle only, so sample mid-cycle
   task automatic rd(input logic [11:0] a, input logic [7:0] exp, input string what);
      @(posedge clk);
      reg_re <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_re <= 1'b0;
      @(negedge clk);
      chk(what, exp, reg_rdata);
   endtask : rd

   // Cold reset with a chosen mode strap
   task automatic cold(input logic [1:0] s);
      @(posedge clk);
      mode_strap <= s;
      sys_rst <= 1'b1;
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : cold

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : tally_and_finish

   // Watchdog: whole run needs about 120 cycles
   initial begin
      repeat (3000) @(posedge clk);
      err_count++;
      $display("watchdog expired");
      tally_and_finish();
   end

   initial begin
      cold(STRAP_MICROCONTROLLER);
      foreach (rows[i]) begin
         if (rows[i].we) begin
            wr(rows[i].a, rows[i].d);
         end else begin
            rd(rows[i].a, rows[i].d, "row read");
         end
      end
      chk("analog flags", ALL_LOW, adc);
      chk("f enables", 8'h03, f_oe);
      chk("f drive", 8'hC3, f_out);
      chk("j drive", 8'h0F, j_out);
      $display("table test done");
      // Warm reset: directions and analog restored, latches kept
      @(posedge clk);
      warm_rst <= 1'b1;
      @(posedge clk);
      warm_rst <= 1'b0;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk("analog flags", ALL_RELEASED, adc);
      chk("j enables", ALL_RELEASED, j_oe);
      rd(A_FD, 8'h00, "f analog read");
      wr(A_JR, 8'h00);
      rd(A_JD, 8'h0F, "j latch kept");
      $display("warm reset test done");
      // Every mode strap, extended last so the bus test follows
      foreach (straps[k]) begin
         cold(straps[k]);
         @(negedge clk);
         chk("bus flag", {7'h00, straps[k] == STRAP_MICROPROCESSOR
            || straps[k] == STRAP_EXTENDED_MICROCONTROLLER}, {7'h00, bus_active});
      end
      @(posedge clk);
      bus_upper_drive <= 1'b1;
      bus_out <= 8'h96;
      wr(A_DR, 8'hFF);
      @(negedge clk);
      chk("d bus out", 8'h96, d_out);
      chk("d bus enables", ALL_LOW, d_oe);
      @(posedge clk);
      bus_upper_drive <= 1'b0;
      wr(A_DR, 8'h00);
      @(negedge clk);
      chk("d released", ALL_RELEASED, d_oe);
      chk("bus capture", EXT_D, bus_in);
      $display("bus mode test done");
      tally_and_finish();
   end
endmodule : multiplexed_parallel_ports_test
